// file: hw/mor_exec.sv
`timescale 1ns/100ps
`default_nettype none
module mor_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // decoded instruction
  input wire logic op_valid,
  input wire mor_pkg::mor_op_t op_sel,
  input wire logic [mor_pkg::MOR_FADDR_W-1:0] op_faddr,
  input wire logic op_ptr_sel,
  input wire logic op_rel,
  input wire logic [1:0] pointer_update_mode,
  input wire logic [5:0] op_offset,
  // core state
  input wire logic [7:0] accumulator_reg,
  input wire logic [mor_pkg::MOR_PC_W-1:0] stack_top,
  // file register write port
  output logic file_we,
  output logic [mor_pkg::MOR_FADDR_W-1:0] file_addr,
  output logic data_we,
  output logic [mor_pkg::MOR_PTR_W-1:0] data_addr,
  output logic [7:0] wr_data,
  // pointers and config
  output logic [mor_pkg::MOR_PTR_W-1:0] file_select_pointer0,
  output logic [mor_pkg::MOR_PTR_W-1:0] file_select_pointer1,
  output logic [7:0] config_reg_main,
  // control to stack, pc and reset logic
  output logic stack_pop,
  output logic pc_load,
  output logic [mor_pkg::MOR_PC_W-1:0] pc_value,
  output logic pc_advance,
  output logic global_irq_enable,
  output logic reset_instr_flag,
  output logic device_reset_req,
  output logic busy,
  output logic status_we
);
  import mor_pkg::*;

  // =========================================
  // pointer arithmetic
  logic [MOR_PTR_W-1:0] fsr_r [2];
  logic [MOR_PTR_W-1:0] cur_ptr;
  logic [MOR_PTR_W-1:0] ptr_nxt;
  logic [MOR_PTR_W-1:0] eff_addr;
  logic [MOR_PTR_W-1:0] sext_k;
  logic ret_cyc_r;
  logic swrst_pend_r;
  logic go;

  // anything offered in the refetch cycle is dropped, not queued
  assign go = op_valid && !ret_cyc_r;
  assign cur_ptr = fsr_r[op_ptr_sel];
  assign sext_k = {{(MOR_PTR_W-6){op_offset[5]}}, op_offset};

  always_comb begin
    // 16-bit add drops the carry, giving the wrap for free
    case (pointer_update_mode)
      MOR_UPD_PREINC, MOR_UPD_POSTINC: ptr_nxt = cur_ptr + MOR_PTR_ONE;
      default: ptr_nxt = cur_ptr - MOR_PTR_ONE;
    endcase
    if (op_rel) begin
      eff_addr = cur_ptr + sext_k;
    end else if (!pointer_update_mode[1]) begin
      eff_addr = ptr_nxt;
    end else begin
      eff_addr = cur_ptr;
    end
  end

  // =========================================
  // pointer registers
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ptr
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          fsr_r[g] <= MOR_PTR_RST;
        end else if (go && op_sel == MOR_OP_STORE_IND && !op_rel &&
                     op_ptr_sel == 1'(g)) begin
          fsr_r[g] <= ptr_nxt;
        end
      end
    end
  endgenerate
  assign file_select_pointer0 = fsr_r[0];
  assign file_select_pointer1 = fsr_r[1];

  // =========================================
  // store paths, one cycle each
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      file_we <= 1'b0;
      data_we <= 1'b0;
      file_addr <= '0;
      data_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      file_we <= go && op_sel == MOR_OP_STORE_DIR;
      data_we <= go && op_sel == MOR_OP_STORE_IND;
      if (go && op_sel == MOR_OP_STORE_DIR) begin
        file_addr <= op_faddr;
        wr_data <= accumulator_reg;
      end
      if (go && op_sel == MOR_OP_STORE_IND) begin
        data_addr <= eff_addr;
        wr_data <= accumulator_reg;
      end
    end
  end

  // =========================================
  // config register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_reg_main <= MOR_CFG_RST;
    end else if (go && op_sel == MOR_OP_OPTION) begin
      config_reg_main <= accumulator_reg;
    end
  end

  // =========================================
  // software reset, flag survives a reset it causes that lasts one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= go && op_sel == MOR_OP_SWRESET;
    end
  end

  // remembers a requested reset until the reset itself arrives
  always_ff @(posedge sys_clk) begin
    if (device_reset_req) begin
      swrst_pend_r <= 1'b1;
    end else if (reset) begin
      swrst_pend_r <= 1'b0;
    end
  end

  // flag is cleared by the instruction; the reset it causes must not set it
  always_ff @(posedge sys_clk) begin
    if (device_reset_req) begin
      reset_instr_flag <= 1'b0;
    end else if (reset && !swrst_pend_r) begin
      reset_instr_flag <= 1'b1;
    end
  end

  // =========================================
  // return from interrupt, second cycle is the refetch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ret_cyc_r <= 1'b0;
      global_irq_enable <= 1'b0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= '0;
    end else begin
      stack_pop <= go && op_sel == MOR_OP_IRQ_RET;
      pc_load <= go && op_sel == MOR_OP_IRQ_RET;
      ret_cyc_r <= go && op_sel == MOR_OP_IRQ_RET;
      if (go && op_sel == MOR_OP_IRQ_RET) begin
        pc_value <= stack_top;
        global_irq_enable <= 1'b1;
      end
    end
  end

  // stall for the flush cycle
  assign busy = ret_cyc_r;
  assign pc_advance = go && op_sel != MOR_OP_IRQ_RET;
  // none of these ops write status
  assign status_we = 1'b0;

  // =========================================
  // checks
  a_dir_store: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_DIR |=> file_we
    && file_addr == $past(op_faddr)
    && wr_data == $past(accumulator_reg))
    else $error("direct store wrong");
  a_ind_addr: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND |=> data_we
    && data_addr == $past(eff_addr))
    else $error("indirect address wrong");
  a_ind_data: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND |=> !file_we
    && wr_data == $past(accumulator_reg))
    else $error("indirect data wrong");
  a_preinc_mode: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel
    && pointer_update_mode == MOR_UPD_PREINC
    |=> data_addr == $past(cur_ptr) + MOR_PTR_ONE)
    else $error("preincrement address wrong");
  a_predec_mode: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel
    && pointer_update_mode == MOR_UPD_PREDEC
    |=> data_addr == $past(cur_ptr) - MOR_PTR_ONE)
    else $error("predecrement address wrong");
  a_postinc_mode: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel && !op_ptr_sel
    && pointer_update_mode == MOR_UPD_POSTINC
    |=> data_addr == $past(cur_ptr)
    && fsr_r[0] == $past(cur_ptr) + MOR_PTR_ONE)
    else $error("postincrement wrong");
  a_postdec_mode: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel && !op_ptr_sel
    && pointer_update_mode == MOR_UPD_POSTDEC
    |=> data_addr == $past(cur_ptr)
    && fsr_r[0] == $past(cur_ptr) - MOR_PTR_ONE)
    else $error("postdecrement wrong");
  a_rel_keep: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && op_rel
    |=> $stable(fsr_r[0]) && $stable(fsr_r[1]))
    else $error("offset form moved pointer");
  a_rel_addr: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && op_rel
    |=> data_addr == $past(cur_ptr) + $past(sext_k))
    else $error("offset address wrong");
  a_wrap_up: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel && !op_ptr_sel
    && pointer_update_mode == MOR_UPD_POSTINC && cur_ptr == 16'hFFFF
    |=> fsr_r[0] == 16'h0000)
    else $error("pointer did not wrap");
  a_wrap_down: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel && op_ptr_sel
    && pointer_update_mode == MOR_UPD_PREDEC && cur_ptr == 16'h0000
    |=> fsr_r[1] == 16'hFFFF)
    else $error("pointer did not wrap down");
  a_no_status: assert property (@(posedge sys_clk) disable iff (reset)
    !status_we) else $error("status written");
  a_cfg_load: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_OPTION |=> config_reg_main == $past(accumulator_reg))
    else $error("config load wrong");
  a_swreset_flag: assert property (@(posedge sys_clk)
    go && op_sel == MOR_OP_SWRESET && !reset |=> device_reset_req
    ##1 !reset_instr_flag)
    else $error("software reset wrong");
  a_flag_kept: assert property (@(posedge sys_clk)
    device_reset_req |=> !reset_instr_flag ##1 !reset_instr_flag)
    else $error("reset flag lost");
  a_ret_seq: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_IRQ_RET |=> stack_pop && pc_load && busy
    && global_irq_enable && pc_value == $past(stack_top) ##1 !busy)
    else $error("return sequence wrong");
  a_busy_refuse: assert property (@(posedge sys_clk) disable iff (reset)
    busy && op_valid |=> !file_we && !data_we && !stack_pop)
    else $error("op taken in refetch cycle");
  a_single_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    go && (op_sel == MOR_OP_STORE_DIR || op_sel == MOR_OP_OPTION)
    |-> pc_advance ##1 !busy)
    else $error("single cycle op stalled");
  a_nop_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_NOP |-> pc_advance ##1 !file_we && !data_we
    && $stable(config_reg_main))
    else $error("nop changed state");
  // =========================================
  // main scenarios
  c_irq_ret: cover property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_IRQ_RET);
  c_ind_rel: cover property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && op_rel);
  c_swreset: cover property (@(posedge sys_clk) device_reset_req);
  c_ptr_wrap: cover property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_STORE_IND && !op_rel && cur_ptr == 16'hFFFF);
  c_cfg_load: cover property (@(posedge sys_clk) disable iff (reset)
    go && op_sel == MOR_OP_OPTION);
endmodule
`default_nettype wire

// file: hw/mor_pkg.sv
package mor_pkg;
  // =========================================
  // operation select codes
  typedef enum logic [2:0] {
    MOR_OP_NONE = 3'h0,
    MOR_OP_STORE_DIR = 3'h1,
    MOR_OP_STORE_IND = 3'h2,
    MOR_OP_NOP = 3'h3,
    MOR_OP_OPTION = 3'h4,
    MOR_OP_SWRESET = 3'h5,
    MOR_OP_IRQ_RET = 3'h6
  } mor_op_t;
  // =========================================
  // pointer update modes
  localparam logic [1:0] MOR_UPD_PREINC = 2'h0;
  localparam logic [1:0] MOR_UPD_PREDEC = 2'h1;
  localparam logic [1:0] MOR_UPD_POSTINC = 2'h2;
  localparam logic [1:0] MOR_UPD_POSTDEC = 2'h3;
  // =========================================
  // widths, positions and reset values
  localparam int MOR_FADDR_W = 7;
  localparam int MOR_PTR_W = 16;
  localparam int MOR_PC_W = 15;
  localparam int MOR_IRQ_EN_BIT = 7;
  localparam logic [7:0] MOR_CFG_RST = 8'hFF;
  localparam logic [15:0] MOR_PTR_RST = 16'h0000;
  localparam logic [15:0] MOR_PTR_ONE = 16'h0001;
  localparam int MOR_IRQ_RET_CYC = 2;
endpackage

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import mor_pkg::*;
  // =========================================
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  mor_op_t op_sel = mor_op_t'(3'h0);
  logic [6:0] op_faddr = 7'h00;
  logic op_ptr_sel = 1'b0;
  logic op_rel = 1'b0;
  logic [1:0] pointer_update_mode = 2'h0;
  logic [5:0] op_offset = 6'h00;
  logic [7:0] accumulator_reg = 8'h00;
  logic [14:0] stack_top = 15'h0000;
  logic file_we, data_we, stack_pop, pc_load, pc_advance, busy, status_we;
  logic global_irq_enable, reset_instr_flag, device_reset_req;
  logic [6:0] file_addr;
  logic [15:0] data_addr, file_select_pointer0, file_select_pointer1;
  logic [7:0] wr_data, config_reg_main;
  logic [14:0] pc_value;
  logic [15:0] exp_p [2] = '{16'h0000, 16'h0000};
  int n_fail = 0;
  int n_checks = 0;
  // =========================================
  // case table: op sel rel mode offset faddr acc, then expected outputs
  typedef struct packed {
    logic [2:0] op; logic sel; logic rel; logic [1:0] mm; logic [5:0] off;
    logic [6:0] fa; logic [7:0] acc; logic fwe; logic dwe;
    logic [15:0] addr; logic [15:0] ptr; logic [7:0] cfg;
  } mor_row_t;
  mor_row_t rows [12] = '{
    '{3'h1,1'b0,1'b0,2'h0,6'h00,7'h7F,8'h4F,1'b1,1'b0,16'h007F,16'h0000,8'hFF},
    '{3'h2,1'b0,1'b0,2'h0,6'h00,7'h00,8'h11,1'b0,1'b1,16'h0001,16'h0001,8'hFF},
    '{3'h2,1'b0,1'b0,2'h2,6'h00,7'h00,8'h22,1'b0,1'b1,16'h0001,16'h0002,8'hFF},
    '{3'h2,1'b0,1'b0,2'h1,6'h00,7'h00,8'h33,1'b0,1'b1,16'h0001,16'h0001,8'hFF},
    '{3'h2,1'b0,1'b0,2'h3,6'h00,7'h00,8'h44,1'b0,1'b1,16'h0001,16'h0000,8'hFF},
    '{3'h2,1'b0,1'b0,2'h3,6'h00,7'h00,8'h55,1'b0,1'b1,16'h0000,16'hFFFF,8'hFF},
    '{3'h2,1'b0,1'b0,2'h0,6'h00,7'h00,8'h66,1'b0,1'b1,16'h0000,16'h0000,8'hFF},
    '{3'h2,1'b1,1'b0,2'h1,6'h00,7'h00,8'h77,1'b0,1'b1,16'hFFFF,16'hFFFF,8'hFF},
    '{3'h2,1'b1,1'b1,2'h0,6'h20,7'h00,8'h88,1'b0,1'b1,16'hFFDF,16'hFFFF,8'hFF},
    '{3'h2,1'b1,1'b1,2'h3,6'h1F,7'h00,8'h99,1'b0,1'b1,16'h001E,16'hFFFF,8'hFF},
    '{3'h4,1'b0,1'b0,2'h0,6'h00,7'h00,8'hA5,1'b0,1'b0,16'h0000,16'h0000,8'hA5},
    '{3'h3,1'b0,1'b0,2'h0,6'h00,7'h00,8'h5A,1'b0,1'b0,16'h0000,16'h0000,8'hA5}};
  mor_exec u_dut (.sys_clk, .reset, .op_valid, .op_sel, .op_faddr,
    .op_ptr_sel, .op_rel, .pointer_update_mode, .op_offset, .accumulator_reg,
    .stack_top, .file_we, .file_addr, .data_we, .data_addr, .wr_data,
    .file_select_pointer0, .file_select_pointer1, .config_reg_main,
    .stack_pop, .pc_load, .pc_value, .pc_advance, .global_irq_enable,
    .reset_instr_flag, .device_reset_req, .busy, .status_we);
  always #5 sys_clk = ~sys_clk;
  // =========================================
  // shared tasks
  task automatic issue(input mor_row_t r);
    @(posedge sys_clk);
    op_sel <= mor_op_t'(r.op);
    op_ptr_sel <= r.sel;
    op_rel <= r.rel;
    pointer_update_mode <= r.mm;
    op_offset <= r.off;
    op_faddr <= r.fa;
    accumulator_reg <= r.acc;
    op_valid <= 1'b1;
    @(negedge sys_clk);
    `CHK("pc_advance", 1'b1, pc_advance)
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // =========================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    `CHK("flag", 1'b1, reset_instr_flag)
    `CHK("irq_en", 1'b0, global_irq_enable)
    `CHK("config", 8'hFF, config_reg_main)
    for (int i = 0; i < 12; i++) begin
      issue(rows[i]);
      exp_p[rows[i].sel] = rows[i].ptr;
      `CHK("file_we", rows[i].fwe, file_we)
      `CHK("data_we", rows[i].dwe, data_we)
      if (rows[i].fwe) `CHK("file_addr", rows[i].addr[6:0], file_addr)
      if (rows[i].dwe) `CHK("data_addr", rows[i].addr, data_addr)
      if (rows[i].fwe | rows[i].dwe) `CHK("wr_data", rows[i].acc, wr_data)
      `CHK("ptr0", exp_p[0], file_select_pointer0)
      `CHK("ptr1", exp_p[1], file_select_pointer1)
      `CHK("config", rows[i].cfg, config_reg_main)
      `CHK("status_we", 1'b0, status_we)
      `CHK("pc_load", 1'b0, pc_load)
      $display("test row %0d done", i);
    end
    // return: a store offered in the busy cycle must be refused
    @(posedge sys_clk);
    stack_top <= 15'h2A5A;
    op_sel <= mor_op_t'(3'h6);
    op_valid <= 1'b1;
    @(negedge sys_clk);
    `CHK("pc_advance", 1'b0, pc_advance)
    @(posedge sys_clk);
    op_sel <= mor_op_t'(3'h1);
    @(negedge sys_clk);
    `CHK("stack_pop", 1'b1, stack_pop)
    `CHK("pc_load", 1'b1, pc_load)
    `CHK("pc_value", 15'h2A5A, pc_value)
    `CHK("irq_en", 1'b1, global_irq_enable)
    `CHK("busy", 1'b1, busy)
    `CHK("status_we", 1'b0, status_we)
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK("busy", 1'b0, busy)
    `CHK("stack_pop", 1'b0, stack_pop)
    `CHK("file_we", 1'b0, file_we)
    $display("test return done");
    // software reset; the bench plays the external reset logic
    @(posedge sys_clk);
    op_sel <= mor_op_t'(3'h5);
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK("reset_req", 1'b1, device_reset_req)
    @(posedge sys_clk);
    reset <= 1'b1;
    @(negedge sys_clk);
    `CHK("flag", 1'b0, reset_instr_flag)
    @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    `CHK("flag", 1'b0, reset_instr_flag)
    `CHK("config", 8'hFF, config_reg_main)
    `CHK("ptr1", 16'h0000, file_select_pointer1)
    `CHK("irq_en", 1'b0, global_irq_enable)
    $display("test software reset done");
    test_done();
  end
  // watchdog, far beyond the forty or so cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
